// [hdl/rag_pkg.sv]
// Constants, types and register map of the clock access guard and alarm block
package rag_pkg;
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned CAL_CLK_HZ = 32_768;
  localparam int unsigned HALF_SEC_MS = 500;
  localparam int unsigned HALF_SEC_CYCLES = SYS_CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int unsigned CAL_PERIOD_CYCLES = (SYS_CLK_HZ + CAL_CLK_HZ - 1) / CAL_CLK_HZ;
  localparam int unsigned SYNC_LEAD_CAL_PERIODS = 32;
  localparam int unsigned SYNC_LEAD_CYCLES = SYNC_LEAD_CAL_PERIODS * CAL_PERIOD_CYCLES;
  localparam int unsigned DLY_W = 11;

  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFF_CTL = 5'h00;
  localparam logic [4:0] OFF_ALM = 5'h04;
  localparam logic [4:0] OFF_TIME = 5'h08;
  localparam logic [4:0] OFF_DATE = 5'h0C;
  localparam logic [4:0] OFF_ATIME = 5'h10;
  localparam logic [4:0] OFF_ADATE = 5'h14;
  localparam logic [4:0] OFF_KEY = 5'h18;

  localparam logic [31:0] KEY_FIRST = 32'hAA996655;
  localparam logic [31:0] KEY_SECOND = 32'h556699AA;

  localparam int unsigned CTL_ON_BIT = 15;
  localparam int unsigned CTL_RUN_BIT = 6;
  localparam int unsigned CTL_WREN_BIT = 3;
  localparam int unsigned CTL_SYNC_BIT = 2;
  localparam int unsigned ALM_EN_BIT = 15;
  localparam int unsigned ALM_CHIME_BIT = 14;
  localparam int unsigned ALM_SYNC_BIT = 12;
  localparam int unsigned ALM_MASK_LSB = 8;
  localparam int unsigned ALM_RPT_LSB = 0;

  localparam logic [31:0] TIME_WMASK = 32'h3F7F7F00;
  localparam logic [31:0] DATE_WMASK = 32'hFF1F3F07;
  localparam logic [31:0] ADATE_WMASK = 32'h001F3F07;
  localparam logic [31:0] TIME_RESET = 32'h00000000;
  localparam logic [31:0] DATE_RESET = 32'h00010106;
  localparam logic [31:0] AREG_RESET = 32'h00000000;

  typedef enum logic [3:0] {
    MASK_HALF_SEC = 4'h0,
    MASK_SEC = 4'h1,
    MASK_TEN_SEC = 4'h2,
    MASK_MIN = 4'h3,
    MASK_TEN_MIN = 4'h4,
    MASK_HOUR = 4'h5,
    MASK_DAY = 4'h6,
    MASK_WEEK = 4'h7,
    MASK_MONTH = 4'h8,
    MASK_YEAR = 4'h9
  } rag_mask_t;

  typedef struct packed {
    logic en;
    logic chime;
    logic [3:0] mask;
    logic [7:0] rpt;
  } rag_alarm_ctl_t;

  localparam rag_alarm_ctl_t ALM_RESET = '{1'b0, 1'b0, 4'h0, 8'h00};

  typedef enum logic [1:0] {
    UNLK_LOCKED = 2'b00,
    UNLK_KEY1 = 2'b01,
    UNLK_KEY2 = 2'b11
  } rag_unlock_t;
endpackage

// [hdl/rag_access_guard.sv]
// Clock access guard: sync windows, key unlock, masked BCD alarm
`timescale 1ns/1ps
module rag_access_guard #(
  parameter int unsigned HALF_CYCLES = rag_pkg::HALF_SEC_CYCLES,
  parameter int unsigned SYNC_LEAD = rag_pkg::SYNC_LEAD_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [rag_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [31:0] cal_next_time_in,
  input wire logic [31:0] cal_next_date_in,
  output logic half_tick_out,
  output logic second_tick_out,
  output logic [31:0] time_out,
  output logic [31:0] date_out,
  output logic alarm_event_out
);
  import rag_pkg::*;

  localparam int unsigned CNT_W = $clog2(HALF_CYCLES);

  logic ack_q;
  logic req;
  logic wr_fire;
  logic [31:0] be_mask;
  logic [31:0] wd_ctl;
  logic [31:0] wd_alm;
  logic on_q;
  logic run_q;
  logic wren_q;
  rag_unlock_t unlk_q;
  logic [CNT_W-1:0] cnt_q;
  logic phase_q;
  logic half_tick;
  logic second_tick;
  logic sync;
  logic [31:0] time_q;
  logic [31:0] date_q;
  logic [31:0] atime_q;
  logic [31:0] adate_q;
  rag_alarm_ctl_t alm_q;
  logic eval_q;
  logic sec_eval_q;
  logic match;
  logic pend_q;
  logic [DLY_W-1:0] dly_q;
  logic alm_fire;
  logic alm_sync;
  logic evt_q;
  logic [31:0] rd_mux;
  logic [31:0] rd_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  function automatic logic is_wr(input logic fire, input logic [4:0] a,
                                 input logic [4:0] off);
    is_wr = fire && (a == off);
  endfunction

  // Digit compare per mask code; reserved bits stay zero so xor is exact
  function automatic logic mask_hit(input logic [3:0] m, input logic full,
                                    input logic [31:0] t, input logic [31:0] d);
    logic tm;
    tm = (t[31:8] == 24'h000000);
    case (m)
      MASK_HALF_SEC: mask_hit = 1'b1;
      MASK_SEC: mask_hit = full;
      MASK_TEN_SEC: mask_hit = full && (t[11:8] == 4'h0);
      MASK_MIN: mask_hit = full && (t[15:8] == 8'h00);
      MASK_TEN_MIN: mask_hit = full && (t[19:8] == 12'h000);
      MASK_HOUR: mask_hit = full && (t[23:8] == 16'h0000);
      MASK_DAY: mask_hit = full && tm;
      MASK_WEEK: mask_hit = full && tm && (d[3:0] == 4'h0);
      MASK_MONTH: mask_hit = full && tm && (d[15:8] == 8'h00);
      MASK_YEAR: mask_hit = full && tm && (d[23:8] == 16'h0000);
      default: mask_hit = 1'b0;
    endcase
  endfunction

  // Every access waits exactly one cycle
  assign req = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = req && !ack_q;
  assign wr_fire = avs_write_in && ack_q;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      be_mask[i*8 +: 8] = {8{avs_byteenable_in[i]}};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Half-second prescaler, idle while the module is off
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !on_q) begin
      cnt_q <= '0;
      phase_q <= 1'b0;
    end else if (half_tick) begin
      cnt_q <= '0;
      phase_q <= !phase_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign half_tick = on_q && (cnt_q == CNT_W'(HALF_CYCLES - 1));
  assign second_tick = half_tick && phase_q;
  assign sync = on_q && (cnt_q >= CNT_W'(HALF_CYCLES - SYNC_LEAD));

  // Unlock sequence: any other write in between drops back to locked
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      unlk_q <= UNLK_LOCKED;
    end else if (wr_fire) begin
      if (avs_address_in == OFF_KEY && avs_byteenable_in == 4'hF) begin
        if (unlk_q == UNLK_LOCKED && avs_writedata_in == KEY_FIRST) begin
          unlk_q <= UNLK_KEY1;
        end else if (unlk_q == UNLK_KEY1 && avs_writedata_in == KEY_SECOND) begin
          unlk_q <= UNLK_KEY2;
        end else begin
          unlk_q <= UNLK_LOCKED;
        end
      end else begin
        unlk_q <= UNLK_LOCKED;
      end
    end
  end

  assign wd_ctl = merge({16'h0000, on_q, 11'h000, wren_q, 3'h0}, avs_writedata_in, be_mask);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      on_q <= 1'b0;
      run_q <= 1'b0;
      wren_q <= 1'b0;
    end else begin
      run_q <= on_q;
      if (is_wr(wr_fire, avs_address_in, OFF_CTL)) begin
        on_q <= wd_ctl[CTL_ON_BIT];
        // Clearing is always allowed, setting only straight after the keys
        wren_q <= wd_ctl[CTL_WREN_BIT] && (wren_q || unlk_q == UNLK_KEY2);
      end
    end
  end

  // Software write wins over a calendar load in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      time_q <= TIME_RESET;
      date_q <= DATE_RESET;
    end else begin
      if (is_wr(wr_fire, avs_address_in, OFF_TIME) && wren_q) begin
        time_q <= merge(time_q, avs_writedata_in, be_mask) & TIME_WMASK;
      end else if (second_tick) begin
        time_q <= cal_next_time_in & TIME_WMASK;
      end
      if (is_wr(wr_fire, avs_address_in, OFF_DATE) && wren_q) begin
        date_q <= merge(date_q, avs_writedata_in, be_mask) & DATE_WMASK;
      end else if (second_tick) begin
        date_q <= cal_next_date_in & DATE_WMASK;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      atime_q <= AREG_RESET;
      adate_q <= AREG_RESET;
    end else begin
      if (is_wr(wr_fire, avs_address_in, OFF_ATIME)) begin
        atime_q <= merge(atime_q, avs_writedata_in, be_mask) & TIME_WMASK;
      end
      if (is_wr(wr_fire, avs_address_in, OFF_ADATE)) begin
        adate_q <= merge(adate_q, avs_writedata_in, be_mask) & ADATE_WMASK;
      end
    end
  end

  // Compare one cycle after the tick, once the new time has loaded
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      eval_q <= 1'b0;
      sec_eval_q <= 1'b0;
    end else begin
      eval_q <= half_tick;
      sec_eval_q <= second_tick;
    end
  end

  assign match = eval_q && alm_q.en && mask_hit(alm_q.mask, sec_eval_q,
                                                 time_q ^ atime_q, date_q ^ adate_q);

  // Match waits one calendar clock period before it fires
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pend_q <= 1'b0;
      dly_q <= '0;
    end else if (!alm_q.en) begin
      pend_q <= 1'b0;
    end else if (match) begin
      pend_q <= 1'b1;
      dly_q <= DLY_W'(CAL_PERIOD_CYCLES - 1);
    end else if (pend_q) begin
      if (dly_q == '0) begin
        pend_q <= 1'b0;
      end else begin
        dly_q <= dly_q - 1'b1;
      end
    end
  end

  assign alm_fire = pend_q && alm_q.en && (dly_q == '0);
  assign alm_sync = alm_q.en && (sync || pend_q);

  assign wd_alm = merge({16'h0000, alm_q.en, alm_q.chime, 2'b00, alm_q.mask, alm_q.rpt},
                        avs_writedata_in, be_mask);

  // A software write to alarm control wins over the hardware update
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      alm_q <= ALM_RESET;
    end else if (is_wr(wr_fire, avs_address_in, OFF_ALM)) begin
      alm_q.en <= wd_alm[ALM_EN_BIT];
      alm_q.chime <= wd_alm[ALM_CHIME_BIT];
      alm_q.mask <= wd_alm[ALM_MASK_LSB +: 4];
      alm_q.rpt <= wd_alm[ALM_RPT_LSB +: 8];
    end else if (alm_fire) begin
      alm_q.rpt <= alm_q.rpt - 8'h01;
      if (!alm_q.chime && alm_q.rpt == 8'h00) begin
        alm_q.en <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= alm_fire;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address_in)
      OFF_CTL: begin
        rd_mux[CTL_ON_BIT] = on_q;
        rd_mux[CTL_RUN_BIT] = run_q;
        rd_mux[CTL_WREN_BIT] = wren_q;
        rd_mux[CTL_SYNC_BIT] = sync;
      end
      OFF_ALM: begin
        rd_mux = {16'h0000, alm_q.en, alm_q.chime, 2'b00, alm_q.mask, alm_q.rpt};
        rd_mux[ALM_SYNC_BIT] = alm_sync;
      end
      OFF_TIME: rd_mux = time_q;
      OFF_DATE: rd_mux = date_q;
      OFF_ATIME: rd_mux = atime_q;
      OFF_ADATE: rd_mux = adate_q;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data captured in the wait cycle, stands at the completing edge
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_q <= 32'h00000000;
    end else if (avs_read_in && !ack_q) begin
      rd_q <= rd_mux;
    end
  end

  assign avs_readdata_out = rd_q;
  assign half_tick_out = half_tick;
  assign second_tick_out = second_tick;
  assign time_out = time_q;
  assign date_out = date_q;
  assign alarm_event_out = evt_q;

  property p_sync_off;
    @(posedge sys_clk_in) disable iff (rst_in)
    !on_q |-> !sync;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync high while off");

  property p_sync_tick;
    @(posedge sys_clk_in) disable iff (rst_in)
    half_tick |-> sync && $past(sync);
  endproperty
  a_sync_tick: assert property (p_sync_tick) else $error("no sync before update");

  property p_time_lock;
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_fire && avs_address_in == OFF_TIME && !wren_q && !second_tick |=> $stable(time_q);
  endproperty
  a_time_lock: assert property (p_time_lock) else $error("locked time changed");

  property p_wren_seq;
    @(posedge sys_clk_in) disable iff (rst_in)
    $rose(wren_q) |-> $past(unlk_q) == UNLK_KEY2 && unlk_q == UNLK_LOCKED;
  endproperty
  a_wren_seq: assert property (p_wren_seq) else $error("enable set out of order");

  property p_alarm_off;
    @(posedge sys_clk_in) disable iff (rst_in)
    !alm_q.en |=> !evt_q && !pend_q;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm while disabled");

  property p_delay;
    @(posedge sys_clk_in) disable iff (rst_in)
    match |=> pend_q && dly_q == DLY_W'(CAL_PERIOD_CYCLES - 1);
  endproperty
  a_delay: assert property (p_delay) else $error("alarm delay wrong");

  property p_half_mask;
    @(posedge sys_clk_in) disable iff (rst_in)
    eval_q && alm_q.en && alm_q.mask == 4'h0 |-> match;
  endproperty
  a_half_mask: assert property (p_half_mask) else $error("half second missed");

  property p_final;
    @(posedge sys_clk_in) disable iff (rst_in)
    alm_fire && !wr_fire && !alm_q.chime && alm_q.rpt == 8'h00 |=> !alm_q.en ##1 !evt_q;
  endproperty
  a_final: assert property (p_final) else $error("last alarm kept enable");

  property p_chime;
    @(posedge sys_clk_in) disable iff (rst_in)
    alm_fire && !wr_fire && alm_q.chime |=> alm_q.en && alm_q.rpt == $past(alm_q.rpt) - 8'h01;
  endproperty
  a_chime: assert property (p_chime) else $error("chime count or enable wrong");

  property p_alm_sync;
    @(posedge sys_clk_in) disable iff (rst_in)
    pend_q && alm_q.en |-> rd_mux[ALM_SYNC_BIT] || avs_address_in != OFF_ALM;
  endproperty
  a_alm_sync: assert property (p_alm_sync) else $error("alarm sync low while pending");
endmodule

// [verification/rtc_access_guard_and_alarm_tb_top.sv]
// Self-checking bench for the clock access guard and alarm block
`timescale 1ns/1ps
module rtc_access_guard_and_alarm_tb_top;
  import rag_pkg::*;
  // Short tick period keeps the run small; must stay above the alarm delay
  localparam int unsigned HC = 1300;
  localparam int unsigned SL = 20;
  localparam logic [31:0] CAL_T = 32'h12345600;
  localparam logic [31:0] CAL_D = 32'h24061503;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic waitreq;
  logic half_tick;
  logic sec_tick;
  logic [31:0] time_o;
  logic [31:0] date_o;
  logic alarm_ev;
  int err_count = 0;
  int checked = 0;
  int events = 0;
  int halves = 0;
  longint cyc = 0;
  longint last_tick = 0;
  longint last_delay = 0;
  logic [31:0] q;

  rag_access_guard #(.HALF_CYCLES(HC), .SYNC_LEAD(SL)) u_dut (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .avs_address_in(addr),
    .avs_read_in(rd),
    .avs_write_in(wr),
    .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq),
    .cal_next_time_in(CAL_T),
    .cal_next_date_in(CAL_D),
    .half_tick_out(half_tick),
    .second_tick_out(sec_tick),
    .time_out(time_o),
    .date_out(date_o),
    .alarm_event_out(alarm_ev)
  );

  initial begin
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // Pre-edge values are sampled, so no race with the design's updates
  always @(posedge sys_clk_in) begin
    cyc++;
    // Seconds land on every second half tick, starting with the second
    if (half_tick === 1'b1) begin
      last_tick = cyc;
      chk("second tick", 32'(sec_tick), 32'(halves % 2));
      halves++;
    end else if (sec_tick === 1'b1) begin
      chk("lone second tick", 32'h1, 32'h0);
    end
    if (alarm_ev === 1'b1) begin
      events++;
      last_delay = cyc - last_tick;
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= is_wr;
    rd <= ~is_wr;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", 32'h1, 32'h0);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rreg(input logic [4:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h00000000, r);
  endtask

  task automatic wait_tick();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (half_tick !== 1'b1 && n < 2 * HC);
    if (n >= 2 * HC) chk("half tick", 32'h0, 32'h1);
  endtask

  // Alarm registers only touched while alarm sync reads zero
  task automatic safe();
    int n;
    logic [31:0] r;
    n = 0;
    do begin
      rreg(OFF_ALM, r);
      n++;
    end while (r[ALM_SYNC_BIT] !== 1'b0 && n < 2000);
    if (n >= 2000) chk("alarm sync", 32'h1, 32'h0);
  endtask

  task automatic arm(input logic [3:0] m, input logic ch, input logic [7:0] rp,
                     input logic [31:0] at);
    wreg(OFF_ALM, 32'h00000000);
    wreg(OFF_ATIME, at);
    wreg(OFF_ADATE, 32'h00061503);
    wreg(OFF_ALM, {16'h0000, 1'b1, ch, 2'b00, m, rp});
  endtask

  task automatic settle(input int n);
    events = 0;
    repeat (n) wait_tick();
    repeat (1250) @(posedge sys_clk_in);
  endtask

  initial begin
    // Tests need about 55000 cycles; a hang ends well inside the run budget
    repeat (90000) @(posedge sys_clk_in);
    err_count++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rreg(OFF_CTL, q);
    chk("control reset", q, 32'h00000000);
    rreg(OFF_DATE, q);
    chk("date reset", q, DATE_RESET);
    chk("date port", date_o, DATE_RESET);
    rreg(OFF_ALM, q);
    chk("alarm reset", q, 32'h00000000);
    rreg(5'h1C, q);
    chk("unmapped", q, 32'h00000000);
    wreg(OFF_TIME, CAL_T);
    rreg(OFF_TIME, q);
    chk("locked time", q, TIME_RESET);
    // Only this bench masters the bus; its own alarm write splits the first sequence
    wreg(OFF_KEY, KEY_FIRST);
    wreg(OFF_ALM, 32'h00000000);
    wreg(OFF_KEY, KEY_SECOND);
    wreg(OFF_CTL, 32'h00000008);
    rreg(OFF_CTL, q);
    chk("broken unlock", q, 32'h00000000);
    wreg(OFF_KEY, KEY_FIRST);
    wreg(OFF_KEY, KEY_SECOND);
    wreg(OFF_CTL, 32'h00000008);
    rreg(OFF_CTL, q);
    chk("unlock", q, 32'h00000008);
    wreg(OFF_TIME, CAL_T);
    rreg(OFF_TIME, q);
    chk("time write off", q, CAL_T);
    chk("time port", time_o, CAL_T);
    rreg(OFF_KEY, q);
    chk("key read", q, 32'h00000000);
    wreg(OFF_KEY, 32'h00000000);
    wreg(OFF_CTL, 32'h00000000);
    wreg(OFF_TIME, 32'h00000000);
    rreg(OFF_TIME, q);
    chk("relocked time", q, CAL_T);
    wreg(OFF_ADATE, 32'hFFFFFFFF);
    rreg(OFF_ADATE, q);
    chk("alarm date bcd", q, ADATE_WMASK);
    wreg(OFF_CTL, 32'h00008000);
    rreg(OFF_CTL, q);
    chk("module on", q, 32'h00008040);
    // Reading twice guards against a read torn by an update
    rreg(OFF_TIME, q);
    chk("time first read", q, CAL_T);
    rreg(OFF_TIME, q);
    chk("time second read", q, CAL_T);
    // Flag low just after a tick, high in the lead before the next
    wait_tick();
    rreg(OFF_CTL, q);
    chk("pending after tick", 32'(q[CTL_SYNC_BIT]), 32'h0);
    repeat (1285) @(posedge sys_clk_in);
    rreg(OFF_CTL, q);
    chk("pending before tick", 32'(q[CTL_SYNC_BIT]), 32'h1);
    // Two repeats: count 1 then 0, then enable drops
    wait_tick();
    arm(4'h0, 1'b0, 8'h01, CAL_T);
    settle(3);
    chk("repeat events", events, 2);
    chk("alarm delay", 32'(last_delay >= 1221 && last_delay <= 1224), 32'h1);
    rreg(OFF_ALM, q);
    chk("repeat done", q, 32'h000000FF);
    wait_tick();
    arm(4'h0, 1'b1, 8'h00, CAL_T);
    repeat (3) @(posedge sys_clk_in);
    wait_tick();
    repeat (4) @(posedge sys_clk_in);
    rreg(OFF_ALM, q);
    chk("alarm sync pending", 32'(q[ALM_SYNC_BIT]), 32'h1);
    settle(2);
    rreg(OFF_ALM, q);
    chk("chime wrap", q & 32'hFFFFEFFF, 32'h0000C0FD);
    safe();
    wreg(OFF_ALM, 32'h00000000);
    settle(2);
    chk("disabled events", events, 0);
    for (int c = 1; c <= 9; c++) begin
      safe();
      wait_tick();
      arm(4'(c), 1'b0, 8'h00, CAL_T);
      settle(2);
      chk("mask events", events, 1);
      rreg(OFF_ALM, q);
      chk("one time", q, 32'h000000FF | (32'(c) << 8));
    end
    safe();
    wait_tick();
    arm(4'h2, 1'b0, 8'h00, 32'h12345300);
    settle(2);
    chk("masked digit differs", events, 0);
    safe();
    wreg(OFF_ALM, 32'h00000000);
    conclude();
  end
endmodule
